/* inc/fc_dio_pkg.sv */
// Constants, types and timing for the counter/frequency and digital I/O register block
package fc_dio_pkg;

	localparam int          DATA_W          = 16;
	localparam int          PORT_W          = 16;
	localparam int          CHANNELS        = 16;
	localparam int          GROUP_CH        = 8;
	localparam int          COUNT_W         = 32;

	// Region codes (base address regions)
	localparam logic [1:0]  REGION_DIO      = 2'h1;
	localparam logic [1:0]  REGION_TIMER0   = 2'h2;
	localparam logic [1:0]  REGION_TIMER1   = 2'h3;

	// Offsets within the digital I/O region
	localparam logic [7:0]  OFS_PORT_A      = 8'h00;
	localparam logic [7:0]  OFS_PORT_B      = 8'h04;
	localparam logic [7:0]  OFS_DIR_STATUS  = 8'h0C;

	// Offsets within a timer region
	localparam logic [7:0]  OFS_CHAN_MODE   = 8'h20;
	localparam logic [7:0]  OFS_SPEED_MODE  = 8'h24;
	localparam logic [7:0]  OFS_SEL_BYTE0   = 8'h40;
	localparam logic [7:0]  OFS_LATCH_BYTE1 = 8'h44;
	localparam logic [7:0]  OFS_BYTE2       = 8'h48;
	localparam logic [7:0]  OFS_CLEAR_BYTE3 = 8'h4C;

	// Field positions
	localparam int          DIR_FIRST_BIT   = 0;
	localparam int          DIR_SECOND_BIT  = 1;
	localparam int          CARD_LSB        = 0;
	localparam int          CARD_W          = 4;
	localparam int          JMP_SECOND_BIT  = 8;
	localparam int          JMP_FIRST_BIT   = 9;
	localparam int          JMP_MODE_BIT    = 10;
	localparam int          SEL_ENABLE_BIT  = 3;
	localparam int          SEL_W           = 3;

	// Reset values
	localparam logic [1:0]  DIR_RST         = 2'h0;
	localparam logic [7:0]  MODE_RST        = 8'h00;
	localparam logic [7:0]  SPEED_RST       = 8'h00;
	localparam logic [15:0] PORT_OUT_RST    = 16'h0000;
	localparam logic [2:0]  SEL_RST         = 3'h0;

	// Timing
	localparam int          CLK_HZ          = 40_000_000;
	localparam int          LOW_GATE_MS     = 1000;
	localparam int          HIGH_GATE_MS    = 10;
	localparam int          LOW_GATE_CYCLES = CLK_HZ / 1000 * LOW_GATE_MS;
	localparam int          HIGH_GATE_CYCLES = CLK_HZ / 1000 * HIGH_GATE_MS;
	localparam int          LOW_SCALE       = 1000 / LOW_GATE_MS;
	localparam int          HIGH_SCALE      = 1000 / HIGH_GATE_MS;
	localparam int          SETTLING_DELAY_MS = 1;

	// Identification codes (values are arbitrary)
	localparam logic [15:0] VENDOR_CODE_DEF = 16'h1234;
	localparam logic [15:0] DEVICE_CODE_DEF = 16'h5678;
	localparam logic [15:0] SUBVEN_CODE_DEF = 16'h9ABC;
	localparam logic [15:0] SUBDEV_CODE_DEF = 16'hDEF0;

	typedef struct packed {
		logic [1:0]        region;
		logic [7:0]        offset;
		logic              wr;
		logic              rd;
		logic [DATA_W-1:0] wdata;
	} io_req_s;

	typedef struct packed {
		logic [15:0] vendor;
		logic [15:0] device;
		logic [15:0] sub_vendor;
		logic [15:0] sub_device;
	} id_codes_s;

endpackage

/* src/fc_channel.sv */
// One counter/frequency channel
`timescale 1ns/10ps
`default_nettype none
module fc_channel (
	input  wire logic                          ref_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          sig_sync,
	input  wire logic                          freq_mode,
	input  wire logic                          high_speed,
	input  wire logic                          gate_low,
	input  wire logic                          gate_high,
	input  wire logic                          clear,
	output logic [fc_dio_pkg::COUNT_W-1:0]     value
);
	import fc_dio_pkg::*;

	logic                 sig_prev_r;
	logic [COUNT_W-1:0]   count_r;
	logic [COUNT_W-1:0]   acc_r;
	logic [COUNT_W-1:0]   freq_r;
	logic                 edge_seen;
	logic                 gate;
	logic [COUNT_W-1:0]   scaled;

	assign edge_seen = sig_sync & ~sig_prev_r;
	assign gate      = high_speed ? gate_high : gate_low;
	assign scaled    = high_speed ? COUNT_W'(acc_r * HIGH_SCALE) : COUNT_W'(acc_r * LOW_SCALE);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sig_prev_r <= 1'b0;
		end else begin
			sig_prev_r <= sig_sync;
		end
	end

	// Live event counter; an edge in the clear cycle still counts
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_r <= '0;
		end else if (clear) begin
			count_r <= edge_seen ? COUNT_W'(1) : '0;
		end else if (edge_seen) begin
			count_r <= count_r + COUNT_W'(1);
		end
	end

	// Edges per gate window, scaled to hertz
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_r  <= '0;
			freq_r <= '0;
		end else if (clear) begin
			acc_r  <= edge_seen ? COUNT_W'(1) : '0;
			freq_r <= '0;
		end else if (gate) begin
			freq_r <= scaled;
			acc_r  <= edge_seen ? COUNT_W'(1) : '0;
		end else if (edge_seen) begin
			acc_r  <= acc_r + COUNT_W'(1);
		end
	end

	assign value = freq_mode ? freq_r : count_r;

endmodule
`default_nettype wire

/* src/counter_frequency_dio_regs.sv */
// Register block for two digital ports and sixteen counter/frequency channels
`timescale 1ns/10ps
`default_nettype none
module counter_frequency_dio_regs #(
	parameter int LOW_GATE_CYC  = fc_dio_pkg::LOW_GATE_CYCLES,
	parameter int HIGH_GATE_CYC = fc_dio_pkg::HIGH_GATE_CYCLES
) (
	input  wire logic                            ref_clk,
	input  wire logic                            sys_rst,
	input  wire fc_dio_pkg::io_req_s             io_req,
	output logic [fc_dio_pkg::DATA_W-1:0]        io_rdata,
	output logic                                 io_rvalid,
	input  wire logic [fc_dio_pkg::PORT_W-1:0]   port_a_in,
	output logic [fc_dio_pkg::PORT_W-1:0]        port_a_out,
	output logic [fc_dio_pkg::PORT_W-1:0]        port_a_oe,
	input  wire logic [fc_dio_pkg::PORT_W-1:0]   port_b_in,
	output logic [fc_dio_pkg::PORT_W-1:0]        port_b_out,
	output logic [fc_dio_pkg::PORT_W-1:0]        port_b_oe,
	input  wire logic [fc_dio_pkg::CARD_W-1:0]   card_number_switch,
	input  wire logic                            jumper_mode_sense,
	input  wire logic                            jumper_first_port_sense,
	input  wire logic                            jumper_second_port_sense,
	input  wire logic [fc_dio_pkg::CHANNELS-1:0] count_in,
	output fc_dio_pkg::id_codes_s                id_codes
);
	import fc_dio_pkg::*;

	localparam int SYNC_W = 2 * PORT_W + CARD_W + 3 + CHANNELS;

	// Pin synchronisers
	logic [SYNC_W-1:0]     sync1_r;
	logic [SYNC_W-1:0]     sync2_r;
	logic [PORT_W-1:0]     port_a_pins;
	logic [PORT_W-1:0]     port_b_pins;
	logic [CARD_W-1:0]     card_pins;
	logic                  jmp_mode;
	logic                  jmp_first;
	logic                  jmp_second;
	logic [CHANNELS-1:0]   count_pins;

	// Digital I/O state
	logic [1:0]            dir_sw_r;
	logic [PORT_W-1:0]     port_a_out_r;
	logic [PORT_W-1:0]     port_b_out_r;
	logic                  first_is_out;
	logic                  second_is_out;

	// Timer state, one entry per group; live values and clear strobes one per channel
	logic [GROUP_CH-1:0]   chan_mode_r  [2];
	logic [GROUP_CH-1:0]   speed_mode_r [2];
	logic [SEL_W-1:0]      sel_r        [2];
	logic [COUNT_W-1:0]    latch_r      [2];
	logic [COUNT_W-1:0]    live_value   [CHANNELS];
	logic [CHANNELS-1:0]   clear_pulse;

	// Gate timebases
	logic [31:0]           low_cnt_r;
	logic [31:0]           high_cnt_r;
	logic                  gate_low;
	logic                  gate_high;

	// Decoded access
	logic                  wr_dio;
	logic                  wr_t   [2];
	logic                  rd_t   [2];
	logic [DATA_W-1:0]     rdata_nxt;
	logic [DATA_W-1:0]     rdata_r;
	logic                  rvalid_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {port_a_in, port_b_in, card_number_switch, jumper_mode_sense,
			            jumper_first_port_sense, jumper_second_port_sense, count_in};
			sync2_r <= sync1_r;
		end
	end

	assign {port_a_pins, port_b_pins, card_pins, jmp_mode, jmp_first, jmp_second, count_pins} = sync2_r;

	assign wr_dio   = io_req.wr && (io_req.region == REGION_DIO);
	assign wr_t[0]  = io_req.wr && (io_req.region == REGION_TIMER0);
	assign wr_t[1]  = io_req.wr && (io_req.region == REGION_TIMER1);
	assign rd_t[0]  = io_req.rd && (io_req.region == REGION_TIMER0);
	assign rd_t[1]  = io_req.rd && (io_req.region == REGION_TIMER1);

	// Software direction register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dir_sw_r <= DIR_RST;
		end else if (wr_dio && io_req.offset == OFS_DIR_STATUS) begin
			dir_sw_r <= {io_req.wdata[DIR_SECOND_BIT], io_req.wdata[DIR_FIRST_BIT]};
		end
	end

	// Jumper in hardware position overrides software direction
	always_comb begin
		if (jmp_mode) begin
			first_is_out  = jmp_first;
			second_is_out = jmp_second;
		end else begin
			first_is_out  = dir_sw_r[0];
			second_is_out = dir_sw_r[1];
		end
	end

	// Output levels of both ports
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			port_a_out_r <= PORT_OUT_RST;
			port_b_out_r <= PORT_OUT_RST;
		end else begin
			if (wr_dio && io_req.offset == OFS_PORT_A) begin
				port_a_out_r <= io_req.wdata;
			end
			if (wr_dio && io_req.offset == OFS_PORT_B) begin
				port_b_out_r <= io_req.wdata;
			end
		end
	end

	assign port_a_out = port_a_out_r;
	assign port_b_out = port_b_out_r;
	assign port_a_oe  = {PORT_W{first_is_out}};
	assign port_b_oe  = {PORT_W{second_is_out}};

	// Mode, speed and selection registers of each group
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int g = 0; g < 2; g++) begin
				chan_mode_r[g]  <= MODE_RST;
				speed_mode_r[g] <= SPEED_RST;
				sel_r[g]        <= SEL_RST;
			end
		end else begin
			for (int g = 0; g < 2; g++) begin
				if (wr_t[g] && io_req.offset == OFS_CHAN_MODE) begin
					chan_mode_r[g] <= io_req.wdata[GROUP_CH-1:0];
				end
				if (wr_t[g] && io_req.offset == OFS_SPEED_MODE) begin
					speed_mode_r[g] <= io_req.wdata[GROUP_CH-1:0];
				end
				if (wr_t[g] && io_req.offset == OFS_SEL_BYTE0 && io_req.wdata[SEL_ENABLE_BIT]) begin
					sel_r[g] <= io_req.wdata[SEL_W-1:0];
				end
			end
		end
	end

	// Latch snapshot of the selected channel, all bits in one edge
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			latch_r[0] <= '0;
			latch_r[1] <= '0;
		end else begin
			for (int g = 0; g < 2; g++) begin
				if (wr_t[g] && io_req.offset == OFS_LATCH_BYTE1) begin
					latch_r[g] <= live_value[g * GROUP_CH + int'(sel_r[g])];
				end
			end
		end
	end

	// Clear strobe to the selected channel; writes to byte 2 fall through
	always_comb begin
		clear_pulse = '0;
		for (int g = 0; g < 2; g++) begin
			if (wr_t[g] && io_req.offset == OFS_CLEAR_BYTE3) begin
				clear_pulse[g * GROUP_CH + int'(sel_r[g])] = 1'b1;
			end
		end
	end

	// Gate timebases for the two frequency ranges
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_cnt_r <= '0;
		end else if (gate_low) begin
			low_cnt_r <= '0;
		end else begin
			low_cnt_r <= low_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			high_cnt_r <= '0;
		end else if (gate_high) begin
			high_cnt_r <= '0;
		end else begin
			high_cnt_r <= high_cnt_r + 32'h1;
		end
	end

	assign gate_low  = (low_cnt_r == 32'(LOW_GATE_CYC - 1));
	assign gate_high = (high_cnt_r == 32'(HIGH_GATE_CYC - 1));

	// Sixteen channels, bit n of a group register drives channel n of the group
	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
		fc_channel u_chan (
			.ref_clk    (ref_clk),
			.sys_rst    (sys_rst),
			.sig_sync   (count_pins[i]),
			.freq_mode  (chan_mode_r[i / GROUP_CH][i % GROUP_CH]),
			.high_speed (speed_mode_r[i / GROUP_CH][i % GROUP_CH]),
			.gate_low   (gate_low),
			.gate_high  (gate_high),
			.clear      (clear_pulse[i]),
			.value      (live_value[i])
		);
	end

	// Read multiplexer
	always_comb begin
		rdata_nxt = '0;
		if (io_req.rd && io_req.region == REGION_DIO) begin
			unique case (io_req.offset)
				OFS_PORT_A: begin
					rdata_nxt = port_a_pins;
				end
				OFS_PORT_B: begin
					rdata_nxt = port_b_pins;
				end
				OFS_DIR_STATUS: begin
					rdata_nxt[CARD_LSB +: CARD_W] = card_pins;
					rdata_nxt[JMP_MODE_BIT]       = jmp_mode;
					rdata_nxt[JMP_FIRST_BIT]      = jmp_first;
					rdata_nxt[JMP_SECOND_BIT]     = jmp_second;
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
		for (int g = 0; g < 2; g++) begin
			if (rd_t[g]) begin
				unique case (io_req.offset)
					OFS_CHAN_MODE: begin
						rdata_nxt = {8'h00, chan_mode_r[g]};
					end
					OFS_SPEED_MODE: begin
						rdata_nxt = {8'h00, speed_mode_r[g]};
					end
					OFS_SEL_BYTE0: begin
						rdata_nxt = {8'h00, latch_r[g][7:0]};
					end
					OFS_LATCH_BYTE1: begin
						rdata_nxt = {8'h00, latch_r[g][15:8]};
					end
					OFS_BYTE2: begin
						rdata_nxt = {8'h00, latch_r[g][23:16]};
					end
					OFS_CLEAR_BYTE3: begin
						rdata_nxt = {8'h00, latch_r[g][31:24]};
					end
					default: begin
						rdata_nxt = '0;
					end
				endcase
			end
		end
	end

	// Registered read answer one cycle after the strobe
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= io_req.rd;
		end
	end

	assign io_rdata  = rdata_r;
	assign io_rvalid = rvalid_r;

	// Fixed identification codes
	assign id_codes.vendor     = VENDOR_CODE_DEF;
	assign id_codes.device     = DEVICE_CODE_DEF;
	assign id_codes.sub_vendor = SUBVEN_CODE_DEF;
	assign id_codes.sub_device = SUBDEV_CODE_DEF;

endmodule
`default_nettype wire

/* bench/regs_monitor.sv */
// Port checks for the register block
`timescale 1ns/10ps
`default_nettype none
module regs_monitor (
	input wire logic                ref_clk,
	input wire logic                sys_rst,
	input wire fc_dio_pkg::io_req_s io_req,
	input wire logic [15:0]         io_rdata,
	input wire logic                io_rvalid,
	input wire logic [15:0]         port_a_out,
	input wire logic [15:0]         port_a_oe,
	input wire logic [15:0]         port_b_oe
);
	import fc_dio_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_read_answer: assert property (io_req.rd |=> io_rvalid)
		else $error("read not answered");
	a_answer_cause: assert property (io_rvalid |-> $past(io_req.rd))
		else $error("answer without read");
	a_unmapped_zero: assert property (io_req.rd && io_req.region == 2'h0 |=> io_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_byte_upper: assert property (io_req.rd && io_req.region[1] && io_req.offset[6] |=> io_rdata[15:8] == 8'h00)
		else $error("byte read upper half set");
	a_status_layout: assert property (io_req.rd && io_req.region == REGION_DIO
		&& io_req.offset == OFS_DIR_STATUS |=> io_rdata[15:11] == 5'h00 && io_rdata[7:4] == 4'h0)
		else $error("status spare bits set");
	a_port_write: assert property (io_req.wr && io_req.region == REGION_DIO
		&& io_req.offset == OFS_PORT_A |=> port_a_out == $past(io_req.wdata))
		else $error("first port output not updated");
	a_oe_uniform: assert property ((port_a_oe == 16'h0000 || port_a_oe == 16'hFFFF)
		&& (port_b_oe == 16'h0000 || port_b_oe == 16'hFFFF))
		else $error("mixed enables in one port");
	a_oe_reset: assert property ($fell(sys_rst) |-> port_a_oe == 16'h0000 && port_b_oe == 16'h0000)
		else $error("port driven after reset");
	a_mode_readback: assert property ((io_req.wr && io_req.region == REGION_TIMER1
		&& io_req.offset == OFS_CHAN_MODE)
		##2 (io_req.rd && io_req.region == REGION_TIMER1 && io_req.offset == OFS_CHAN_MODE)
		|=> io_rdata[7:0] == $past(io_req.wdata[7:0], 3))
		else $error("channel mode not read back");
endmodule
bind counter_frequency_dio_regs regs_monitor u_regs_monitor (.ref_clk, .sys_rst, .io_req, .io_rdata,
	.io_rvalid, .port_a_out, .port_a_oe, .port_b_oe);
`default_nettype wire

/* bench/host_bfm.sv */
// Host model issuing register requests
`timescale 1ns/10ps
`default_nettype none
module host_bfm (
	input  wire logic               ref_clk,
	input  wire logic [15:0]        io_rdata,
	input  wire logic               io_rvalid,
	output var fc_dio_pkg::io_req_s io_req
);
	import fc_dio_pkg::*;
	int gap = 0;
	initial io_req = '0;
	task automatic req(input logic [1:0] rg, input logic [7:0] of, input logic [15:0] d, input logic r);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		#1 io_req = '{region: rg, offset: of, wr: !r, rd: r, wdata: d};
		@(posedge ref_clk);
		#1 io_req = '{region: rg, offset: ~of, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask
	task automatic wr(input logic [1:0] rg, input logic [7:0] of, input logic [15:0] d);
		req(rg, of, d, 1'b0);
	endtask
	task automatic rd(input logic [1:0] rg, input logic [7:0] of, output logic [15:0] q);
		req(rg, of, 16'h0000, 1'b1);
		q = io_rvalid ? io_rdata : 16'hXXXX;
	endtask
	task automatic pick(input logic [1:0] rg, input logic [2:0] ch);
		wr(rg, OFS_SEL_BYTE0, {12'h000, 1'b1, ch});
		wr(rg, OFS_LATCH_BYTE1, {13'h0000, ch});
	endtask
	task automatic get32(input logic [1:0] rg, output logic [31:0] v);
		logic [15:0] q;
		for (int i = 0; i < 4; i++) begin
			rd(rg, OFS_SEL_BYTE0 + 8'(4 * i), q);
			v[8*i +: 8] = q[7:0];
		end
	endtask
endmodule
`default_nettype wire

/* bench/tb_counter_frequency_dio_regs.sv */
// Self-checking bench for the counter and digital port register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_counter_frequency_dio_regs;
	import fc_dio_pkg::*;
	localparam int LOWG = 40;
	localparam int HIGHG = 20;
	logic        ref_clk, sys_rst, io_rvalid;
	io_req_s     io_req;
	id_codes_s   id_codes;
	logic [15:0] io_rdata, port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe, count_in, q;
	logic [3:0]  card_number_switch;
	logic        jumper_mode_sense, jumper_first_port_sense, jumper_second_port_sense;
	int          mismatches, checks, cycles;
	counter_frequency_dio_regs #(.LOW_GATE_CYC(LOWG), .HIGH_GATE_CYC(HIGHG)) u_counter_frequency_dio_regs (
		.ref_clk, .sys_rst, .io_req, .io_rdata, .io_rvalid, .port_a_in, .port_a_out, .port_a_oe,
		.port_b_in, .port_b_out, .port_b_oe, .card_number_switch, .jumper_mode_sense,
		.jumper_first_port_sense, .jumper_second_port_sense, .count_in, .id_codes);
	host_bfm u_host_bfm (.ref_clk, .io_rdata, .io_rvalid, .io_req);
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	always begin
		repeat (2) @(posedge ref_clk);
		count_in[0] <= ~count_in[0];
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rchk(input logic [1:0] rg, input logic [7:0] of, input logic [15:0] e);
		u_host_bfm.rd(rg, of, q);
		`CHK(q, e)
	endtask
	task automatic c32(input logic [1:0] rg, input logic [2:0] ch, input bit lt, input logic [31:0] e);
		logic [31:0] v;
		if (lt)
			u_host_bfm.pick(rg, ch);
		u_host_bfm.get32(rg, v);
		`CHK(v, e)
	endtask
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			count_in[b] = 1'b1;
			repeat (2) @(posedge ref_clk);
			#1 count_in[b] = 1'b0;
			repeat (2) @(posedge ref_clk);
			#1;
		end
	endtask
	initial begin
		sys_rst = 1'b1;
		{port_a_in, port_b_in, count_in} = '0;
		card_number_switch = 4'hA;
		{jumper_mode_sense, jumper_first_port_sense, jumper_second_port_sense} = 3'h0;
		repeat (6) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		`CHK(port_a_oe | port_b_oe, 16'h0000)
		`CHK(id_codes, {VENDOR_CODE_DEF, DEVICE_CODE_DEF, SUBVEN_CODE_DEF, SUBDEV_CODE_DEF})
		repeat (2) @(posedge ref_clk);
		#1;
		rchk(REGION_DIO, OFS_DIR_STATUS, 16'h000A);
		for (int g = 2; g < 4; g++) begin
			rchk(2'(g), OFS_CHAN_MODE, 16'h0000);
			rchk(2'(g), OFS_SPEED_MODE, 16'h0000);
		end
		$display("reset test done");
		for (int d = 0; d < 4; d++) begin
			u_host_bfm.wr(REGION_DIO, OFS_DIR_STATUS, {14'h3FFF, 2'(d)});
			`CHK({port_b_oe, port_a_oe}, {{16{d[1]}}, {16{d[0]}}})
		end
		jumper_mode_sense = 1'b1;
		for (int j = 0; j < 4; j++) begin
			{jumper_first_port_sense, jumper_second_port_sense} = 2'(j);
			repeat (3) @(posedge ref_clk);
			#1 `CHK({port_a_oe, port_b_oe}, {{16{j[1]}}, {16{j[0]}}})
			rchk(REGION_DIO, OFS_DIR_STATUS, {5'h00, 1'b1, 2'(j), 8'h0A});
		end
		jumper_mode_sense = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 `CHK(port_a_oe & port_b_oe, 16'hFFFF)
		$display("direction test done");
		u_host_bfm.wr(REGION_DIO, OFS_PORT_A, 16'hA5C3);
		`CHK(port_a_out, 16'hA5C3)
		u_host_bfm.wr(REGION_DIO, OFS_PORT_B, 16'h3C5A);
		`CHK(port_b_out, 16'h3C5A)
		port_a_in = 16'h1234;
		port_b_in = 16'hFEDC;
		repeat (3) @(posedge ref_clk);
		rchk(REGION_DIO, OFS_PORT_A, 16'h1234);
		rchk(REGION_DIO, OFS_PORT_B, 16'hFEDC);
		$display("port test done");
		u_host_bfm.wr(REGION_TIMER1, OFS_CHAN_MODE, 16'h00A5);
		rchk(REGION_TIMER1, OFS_CHAN_MODE, 16'h00A5);
		u_host_bfm.wr(REGION_TIMER1, OFS_SPEED_MODE, 16'h005A);
		rchk(REGION_TIMER1, OFS_SPEED_MODE, 16'h005A);
		u_host_bfm.wr(REGION_TIMER1, OFS_CHAN_MODE, 16'h0000);
		u_host_bfm.gap = 3;
		rchk(2'h0, 8'h00, 16'h0000);
		rchk(REGION_DIO, 8'h08, 16'h0000);
		u_host_bfm.gap = 0;
		$display("register test done");
		pulse(3, 5);
		c32(REGION_TIMER0, 3'h3, 1'b1, 32'd5);
		pulse(3, 2);
		c32(REGION_TIMER0, 3'h3, 1'b0, 32'd5);
		c32(REGION_TIMER0, 3'h3, 1'b1, 32'd7);
		u_host_bfm.wr(REGION_TIMER0, OFS_BYTE2, 16'hFFFF);
		u_host_bfm.wr(REGION_TIMER0, OFS_SEL_BYTE0, 16'h0005);
		u_host_bfm.wr(REGION_TIMER0, OFS_LATCH_BYTE1, 16'h0005);
		c32(REGION_TIMER0, 3'h3, 1'b0, 32'd7);
		u_host_bfm.wr(REGION_TIMER0, OFS_CLEAR_BYTE3, 16'h0000);
		c32(REGION_TIMER0, 3'h3, 1'b1, 32'd0);
		pulse(11, 3);
		c32(REGION_TIMER1, 3'h3, 1'b1, 32'd3);
		$display("count test done");
		u_host_bfm.wr(REGION_TIMER0, OFS_CHAN_MODE, 16'h0001);
		u_host_bfm.wr(REGION_TIMER0, OFS_SPEED_MODE, 16'h0001);
		repeat (3 * HIGHG) @(posedge ref_clk);
		c32(REGION_TIMER0, 3'h0, 1'b1, 32'(HIGHG / 4 * HIGH_SCALE));
		u_host_bfm.wr(REGION_TIMER0, OFS_SPEED_MODE, 16'h0000);
		repeat (3 * LOWG) @(posedge ref_clk);
		c32(REGION_TIMER0, 3'h0, 1'b1, 32'(LOWG / 4 * LOW_SCALE));
		$display("frequency test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
